//--- src/cbt_map.svh
// Constants for the two-line control bus timing ends.
// Assumes a 40 MHz local clock on both ends.
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH
`define CBT_CLK_NS        25
`define CBT_LOSS_NS       1300000
`define CBT_PROG_NS       40000000
`define CBT_LOSS_CYC      ((`CBT_LOSS_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_PROG_CYC      ((`CBT_PROG_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_HALF_CYC      4
`define CBT_FRAME_BITS    16
`define CBT_GAP_BITS      4
`define CBT_NODE_SLOT     5
`endif

//--- src/cbt_pkg.sv
// Types shared by the bus node and the bus clock source.
// Assumes cbt_map.svh holds the numbers.
package cbt_pkg;
  typedef enum logic [1:0] {
    CBT_SRC_HALT,
    CBT_SRC_RUN,
    CBT_SRC_GAP
  } cbt_src_state_t;
endpackage : cbt_pkg

//--- src/cbt_bus_if.sv
// Two-line bus: clock driven totem-pole, data open-drain with pull-up.
// Assumes the bench ties this instance between the two ends.
`timescale 1ns/1ps
interface cbt_bus_if;
  logic bus_clk;
  logic data_oe_src;
  logic data_oe_node;
  wire  data_line = ~(data_oe_src | data_oe_node);
  modport src (
    output bus_clk,
    output data_oe_src,
    input  data_line
  );
  modport node (
    input  bus_clk,
    output data_oe_node,
    input  data_line
  );
endinterface : cbt_bus_if

//--- src/cbt_src.sv
// Bus clock source: divides the local clock into bus clock frames.
// Assumes frames of FRAME_BITS pulses separated by a high gap.
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_src #(
  parameter int FRAME_BITS = `CBT_FRAME_BITS,
  parameter int HALF_CYC   = `CBT_HALF_CYC,
  parameter int GAP_BITS   = `CBT_GAP_BITS,
  parameter int LOSS_CYC   = `CBT_LOSS_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic en_i,
  // User side
  input  wire logic run_i,
  output logic      frame_start_o,
  output logic      bit_vld_o,
  output logic      bit_val_o,
  // Bus side
  cbt_bus_if.src    bus
);
  import cbt_pkg::*;

  cbt_src_state_t st_q, st_d;
  logic [31:0]    cnt_q, cnt_d;
  logic [15:0]    bit_q, bit_d;
  logic           clk_q, clk_d;
  logic           d1_q, d2_q;
  logic           fs_q, fs_d, bv_q, bv_d, bval_q, bval_d;
  // Falls wait two cycles so the synchronised data matches the fall edge
  logic [1:0]     pv_q, pv_d, pf_q, pf_d;
  logic           fev;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    bit_d  = bit_q;
    clk_d  = clk_q;
    fs_d   = 1'b0;
    bv_d   = 1'b0;
    bval_d = bval_q;
    case (st_q)
      // Halt first so every node sees a clock loss
      CBT_SRC_HALT: begin
        clk_d = 1'b1;
        if (cnt_q < 32'(LOSS_CYC)) cnt_d = cnt_q + 32'h1;
        else if (run_i) begin
          st_d  = CBT_SRC_GAP;
          cnt_d = '0;
        end
      end
      // Gap holds the line high, no pulses
      CBT_SRC_GAP: begin
        clk_d = 1'b1;
        cnt_d = cnt_q + 32'h1;
        if (!run_i) begin
          st_d  = CBT_SRC_HALT;
          cnt_d = '0;
        end else if (cnt_q == 32'(2 * HALF_CYC * GAP_BITS - 1)) begin
          st_d  = CBT_SRC_RUN;
          cnt_d = '0;
          bit_d = '0;
          clk_d = 1'b0;
          fs_d  = 1'b1;
        end
      end
      // One pulse per bit, half duty
      CBT_SRC_RUN: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(HALF_CYC - 1)) clk_d = 1'b1;
        if (cnt_q == 32'(2 * HALF_CYC - 1)) begin
          clk_d  = 1'b0;
          cnt_d  = '0;
          bit_d  = bit_q + 16'h1;
          if (bit_q == 16'(FRAME_BITS - 1)) begin
            st_d  = CBT_SRC_GAP;
            clk_d = 1'b1;
          end
        end
      end
      default: st_d = CBT_SRC_HALT;
    endcase
    // Falling edge: sample data, low-true
    fev  = clk_q & ~clk_d;
    pv_d = {pv_q[0], fev};
    pf_d = {pf_q[0], fs_d};
    bv_d = pv_q[1];
    if (pv_q[1]) bval_d = ~d2_q;
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q   <= CBT_SRC_HALT;
      cnt_q  <= '0;
      bit_q  <= '0;
      clk_q  <= 1'b1;
      d1_q   <= 1'b1;
      d2_q   <= 1'b1;
      fs_q   <= 1'b0;
      bv_q   <= 1'b0;
      bval_q <= 1'b0;
      pv_q   <= '0;
      pf_q   <= '0;
    end else if (en_i) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      bit_q  <= bit_d;
      clk_q  <= clk_d;
      d1_q   <= bus.data_line;
      d2_q   <= d1_q;
      fs_q   <= pf_q[1];
      bv_q   <= bv_d;
      bval_q <= bval_d;
      pv_q   <= pv_d;
      pf_q   <= pf_d;
    end
  end

  assign bus.bus_clk     = clk_q;
  assign bus.data_oe_src = 1'b0;
  assign frame_start_o   = fs_q;
  assign bit_vld_o       = bv_q;
  assign bit_val_o       = bval_q;
endmodule : cbt_src

//--- src/cbt_node.sv
// Bus I/O node: drives one bit slot, samples all bits but the first after a clock loss, watches the clock.
// Assumes the bus clock is asynchronous to clk_sys_i.
`timescale 1ns/1ps
`include "cbt_map.svh"
module cbt_node #(
  parameter int SLOT       = `CBT_NODE_SLOT,
  parameter int LOSS_CYC   = `CBT_LOSS_CYC,
  parameter int PROG_CYC   = `CBT_PROG_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  input  wire logic en_i,
  // Transmit word for own slot
  input  wire logic tx_vld_i,
  input  wire logic tx_bit_i,
  output logic      tx_rdy_o,
  // Received bits
  output logic      rx_vld_o,
  output logic      rx_bit_o,
  output logic [15:0] rx_idx_o,
  input  wire logic rx_rdy_i,
  // Status
  output logic      clk_loss_o,
  output logic      prog_mode_o,
  // Bus side
  cbt_bus_if.node   bus
);
  import cbt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers; two stages then the edge detector
  logic c1_q, c2_q, c3_q, d1_q, d2_q;
  logic rise, fall;
  // A pin comparator holds hysteresis; the two flops only synchronise and pass glitches through
  assign rise = c2_q & ~c3_q;
  assign fall = ~c2_q & c3_q;

  ////////////////////////////////////////////////////////////////////////
  // Two-entry transmit buffer; a stalled writer loses nothing
  logic [1:0] buf_q, buf_d;
  logic [1:0] cntb_q, cntb_d;
  logic       rd_q, rd_d;
  logic       pop;

  ////////////////////////////////////////////////////////////////////////
  // Slot counter, drive, timeouts
  logic [15:0] idx_q, idx_d;
  logic        oe_q, oe_d;
  logic [31:0] loss_q, loss_d, prog_q, prog_d;
  logic        lost_q, lost_d, pm_q, pm_d;
  logic        rv_q, rv_d, rb_q, rb_d;
  logic [15:0] ri_q, ri_d;

  always_comb begin
    idx_d  = idx_q;
    oe_d   = oe_q;
    loss_d = loss_q;
    prog_d = prog_q;
    lost_d = lost_q;
    pm_d   = pm_q;
    rv_d   = rv_q & ~rx_rdy_i;
    rb_d   = rb_q;
    ri_d   = ri_q;
    pop    = 1'b0;
    // Loss counter restarts on each falling edge
    if (fall) begin
      loss_d = '0;
      lost_d = 1'b0;
    end else if (loss_q < 32'(LOSS_CYC)) loss_d = loss_q + 32'h1;
    else lost_d = 1'b1;
    // Programming counter restarts while clock low
    if (!c2_q) prog_d = '0;
    else if (prog_q < 32'(PROG_CYC)) prog_d = prog_q + 32'h1;
    else pm_d = 1'b1;
    if (!c2_q) pm_d = 1'b0;
    if (lost_q) begin
      // Defaults restored, ready for a fresh start
      idx_d = '0;
      oe_d  = 1'b0;
    end
    if (rise) begin
      // Release at once, then drive own slot
      oe_d = 1'b0;
      if (idx_q == 16'(SLOT) && cntb_q != 2'h0) begin
        oe_d = buf_q[rd_q];
        pop  = 1'b1;
      end
    end
    // Slot count runs even on the skipped first fall, keeping slots aligned
    if (fall) idx_d = idx_q + 16'h1;
    if (fall && !lost_q) begin
      // Only falling edges sample data
      rv_d  = 1'b1;
      rb_d  = ~d2_q;
      ri_d  = idx_q;
    end
    // Wait in the gap means the frame ended; next pulse is slot 0
    if (c2_q && loss_q == 32'(`CBT_HALF_CYC * 4)) idx_d = '0;
  end

  always_comb begin
    buf_d  = buf_q;
    cntb_d = cntb_q;
    rd_d   = rd_q;
    if (tx_vld_i && cntb_q != 2'h2)
      buf_d[rd_q ^ cntb_q[0]] = tx_bit_i;
    if (pop) rd_d = ~rd_q;
    cntb_d = cntb_q + {1'b0, tx_vld_i && cntb_q != 2'h2} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      c1_q   <= 1'b1;
      c2_q   <= 1'b1;
      c3_q   <= 1'b1;
      d1_q   <= 1'b1;
      d2_q   <= 1'b1;
      buf_q  <= '0;
      cntb_q <= '0;
      rd_q   <= 1'b0;
      idx_q  <= '0;
      oe_q   <= 1'b0;
      loss_q <= '0;
      prog_q <= '0;
      lost_q <= 1'b1;
      pm_q   <= 1'b0;
      rv_q   <= 1'b0;
      rb_q   <= 1'b0;
      ri_q   <= '0;
    end else if (en_i) begin
      c1_q   <= bus.bus_clk;
      c2_q   <= c1_q;
      c3_q   <= c2_q;
      d1_q   <= bus.data_line;
      d2_q   <= d1_q;
      buf_q  <= buf_d;
      cntb_q <= cntb_d;
      rd_q   <= rd_d;
      idx_q  <= idx_d;
      oe_q   <= oe_d;
      loss_q <= loss_d;
      prog_q <= prog_d;
      lost_q <= lost_d;
      pm_q   <= pm_d;
      rv_q   <= rv_d;
      rb_q   <= rb_d;
      ri_q   <= ri_d;
    end
  end

  logic trdy_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) trdy_q <= 1'b1;
    else if (en_i) trdy_q <= (cntb_d != 2'h2);
  end

  assign bus.data_oe_node = oe_q;
  assign tx_rdy_o    = trdy_q;
  assign rx_vld_o    = rv_q;
  assign rx_bit_o    = rb_q;
  assign rx_idx_o    = ri_q;
  assign clk_loss_o  = lost_q;
  assign prog_mode_o = pm_q;
endmodule : cbt_node

//--- tb/cbt_checker.sv
// Assertions on the bus wires between clock source and node.
// Assumes 4 local cycles per bus half period, as the source makes.
`timescale 1ns/1ps
module cbt_checker (
  // Local clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Bus wires
  input  wire logic bus_clk,
  input  wire logic data_oe_src,
  input  wire logic data_oe_node,
  input  wire logic data_line
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  //////////////////////////////////////////////////////////////////////////
  property p_hi;
    $rose(bus_clk) |-> bus_clk[*4];
  endproperty
  a_hi: assert property (p_hi)
    else $error("bus clock high half too short");
  property p_lo;
    $fell(bus_clk) |-> !bus_clk[*4] ##1 bus_clk;
  endproperty
  a_lo: assert property (p_lo)
    else $error("bus clock low half not four cycles");
  // Sync delay puts the node's edge three or four cycles behind the rise
  property p_on;
    $rose(data_oe_node) |->
      $past(bus_clk, 3) && !($past(bus_clk, 4) && $past(bus_clk, 5));
  endproperty
  a_on: assert property (p_on)
    else $error("node drive not tied to bus clock rise");
  property p_off;
    $fell(data_oe_node) |->
      $past(bus_clk, 3) && !($past(bus_clk, 4) && $past(bus_clk, 5));
  endproperty
  a_off: assert property (p_off)
    else $error("node release not tied to bus clock rise");
  property p_hold;
    $rose(data_oe_node) |-> data_oe_node[*7];
  endproperty
  a_hold: assert property (p_hold)
    else $error("node drive shorter than a bit period");
  property p_src;
    !data_oe_src;
  endproperty
  a_src: assert property (p_src)
    else $error("source pulls the data line");
  property p_wire;
    data_oe_node |-> !data_line;
  endproperty
  a_wire: assert property (p_wire)
    else $error("driven one does not pull line low");
  property p_gap;
    bus_clk[*8] |-> !data_oe_node;
  endproperty
  a_gap: assert property (p_gap)
    else $error("node drives while clock rests high");
endmodule : cbt_checker

//--- tb/bus_node_clock_data_timing_tb.sv
// Bench: clock source and node joined by the bus, model in queues.
// Assumes shortened loss and programming counts.
`timescale 1ns/1ps
module bus_node_clock_data_timing_tb;
  localparam int SLOT = 5;
  localparam int LOSS = 200;
  localparam int PROG = 400;
  logic clk_sys_i = 0, arst_n_i = 0, en_i = 0, run_i = 0;
  logic tx_vld_i = 0, tx_bit_i = 0, rx_rdy_i = 0, bc_q = 1;
  logic frame_start_o, bit_vld_o, bit_val_o, tx_rdy_o, rx_vld_o, rx_bit_o;
  logic clk_loss_o, prog_mode_o;
  logic [15:0] rx_idx_o;
  int   err_total = 0, n_tests = 0, hi = 0, widx = 0, sidx = -1, i;
  logic e, chk = 0;
  logic q[$];
  logic wbits[16];
  //////////////////////////////////////////////////////////////////////////
  cbt_bus_if u_bus ();
  cbt_src #(.LOSS_CYC(LOSS)) u_cbt_src (.clk_sys_i, .arst_n_i, .en_i,
    .run_i, .frame_start_o, .bit_vld_o, .bit_val_o, .bus(u_bus.src));
  cbt_node #(.SLOT(SLOT), .LOSS_CYC(LOSS), .PROG_CYC(PROG)) u_cbt_node (
    .clk_sys_i, .arst_n_i, .en_i, .tx_vld_i, .tx_bit_i, .tx_rdy_o,
    .rx_vld_o, .rx_bit_o, .rx_idx_o, .rx_rdy_i, .clk_loss_o, .prog_mode_o,
    .bus(u_bus.node));
  cbt_checker u_chk (.clk_sys_i, .arst_n_i, .bus_clk(u_bus.bus_clk),
    .data_oe_src(u_bus.data_oe_src), .data_oe_node(u_bus.data_oe_node),
    .data_line(u_bus.data_line));
  //////////////////////////////////////////////////////////////////////////
  task check(string nm, logic [15:0] ex, logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  task print_verdict;
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  //////////////////////////////////////////////////////////////////////////
  // Wire watch one cycle after a fall, so a late drive edge cannot race it
  always @(posedge clk_sys_i) begin
    bc_q <= u_bus.bus_clk;
    hi <= u_bus.bus_clk ? hi + 1 : 0;
    if (bc_q && !u_bus.bus_clk) begin
      widx = (hi > 8) ? 0 : widx + 1;
      wbits[widx % 16] = ~u_bus.data_line;
    end
    if (clk_loss_o) sidx = -1;
    if (bit_vld_o) begin
      if (frame_start_o) begin
        if (sidx >= 0) check("src bits", 15, sidx);
        sidx = 0;
      end else sidx++;
      if (sidx >= 0) check("src val", wbits[sidx % 16], bit_val_o);
    end
    if (chk && rx_vld_o && rx_rdy_i) begin
      e = (rx_idx_o == SLOT && q.size() > 0) ? q.pop_front() : 1'b0;
      check("rx bit", e, rx_bit_o);
      check("wire bit", e, wbits[rx_idx_o % 16]);
    end
    if (tx_vld_i && tx_rdy_o) q.push_back(tx_bit_i);
    if (!tx_vld_i || tx_rdy_o) tx_bit_i <= 1'($urandom % 2);
    rx_rdy_i <= (($urandom % 4) != 0);
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h6b63));
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1;
    en_i <= 1;
    tx_vld_i <= 1;
    repeat (6) @(posedge clk_sys_i);
    check("loss at start", 1, clk_loss_o);
    check("tx refused", 0, tx_rdy_o);
    check("queued", 2, q.size());
    chk = 1;
    run_i <= 1;
    repeat (2500) @(posedge clk_sys_i);
    check("loss cleared", 0, clk_loss_o);
    run_i <= 0;
    tx_vld_i <= 0;
    chk = 0;
    for (i = 0; i < 1000 && !clk_loss_o; i++) @(posedge clk_sys_i);
    check("loss time", 1, hi + 4 >= LOSS && hi <= LOSS + 8);
    check("no prog yet", 0, prog_mode_o);
    for (i = 0; i < 1000 && !prog_mode_o; i++) @(posedge clk_sys_i);
    check("prog time", 1, hi >= PROG && hi <= PROG + 8);
    run_i <= 1;
    for (i = 0; i < 2000 && clk_loss_o; i++) @(posedge clk_sys_i);
    check("restart", 0, clk_loss_o);
    check("prog left", 0, prog_mode_o);
    print_verdict();
  end
endmodule : bus_node_clock_data_timing_tb
